// ---- dv/tb_top.sv ----
// Purpose: self-checking bench for the wake frame byte masks
// Assumes: 100 MHz clock, synchronous active-low reset held 6 cycles
// Notes: crc expectations come from a bench-side reference model
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wfm_pkg::*;
  localparam logic [3:0][31:0] MK = {32'hfedc1234, 32'hffff0000, 32'hffffffff, 32'h80018001};
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  wfm_reg_req_t req = '0;
  wfm_byte_t rx = '0;
  logic [15:0] rdata;
  logic rvalid;
  logic [3:0][31:0] res;
  logic [3:0] done;
  logic [3:0][31:0] want;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  // clock and watchdog
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  wfm_masks dut (.CLK(CLK), .RST_N(RST_N), .REG_REQ(req), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .RX_BYTE(rx), .CRC_RESULT(res), .CRC_DONE(done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge CLK);
    req <= '{wr: 1'b1, rd: 1'b0, devad: WFM_DEVAD, addr: a, wdata: d};
    @(posedge CLK);
    req.wr <= 1'b0;
  endtask
  // read one word and compare marker and data
  task automatic rdchk(input logic [15:0] a, input logic [4:0] dv, input logic [15:0] e);
    @(posedge CLK);
    req <= '{wr: 1'b0, rd: 1'b1, devad: dv, addr: a, wdata: 16'h0000};
    @(posedge CLK);
    req.rd <= 1'b0;
    #1;
    chk({31'h0, rvalid}, 32'h1);
    chk({16'h0, rdata}, {16'h0, e});
  endtask
  // bit k of m selects frame byte k+1, deselected bytes skipped
  function automatic logic [31:0] ref_crc(input logic [31:0] m, input logic [7:0] s);
    logic [31:0] c;
    logic [7:0] d;
    c = 32'hffffffff;
    for (int k = 0; k < 32; k++) begin
      d = 8'(k * 37) ^ s;
      for (int i = 0; i < 8; i++) begin
        if (m[k]) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
      end
    end
    return ~c;
  endfunction
  // 34 bytes with an idle gap; bytes past 32 must be ignored
  task automatic send_frame(input logic [7:0] s, input logic [3:0] en_exp);
    for (int k = 0; k < 34; k++) begin
      if (k == 9) begin
        @(posedge CLK);
        rx.valid <= 1'b0;
      end
      @(posedge CLK);
      rx <= '{valid: 1'b1, sof: k == 0, data: 8'(k * 37) ^ s};
      // done pulse stands just after byte 33 is taken
      if (k == 33) begin
        #1;
        chk({28'h0, done}, {28'h0, en_exp});
      end
    end
    @(posedge CLK);
    rx.valid <= 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    chk({28'h0, done}, 32'h0);
  endtask
  task automatic set_masks(input logic [31:0] x);
    for (int t = 0; t < 4; t++) begin
      wr(WFM_OFS_LOW[t], MK[t][15:0] ^ x[15:0]);
      wr(WFM_OFS_HIGH[t], MK[t][31:16] ^ x[31:16]);
    end
  endtask
  task automatic t_reset();
    for (int t = 0; t < 4; t++) begin
      rdchk(WFM_OFS_LOW[t], WFM_DEVAD, 16'h0000);
      rdchk(WFM_OFS_HIGH[t], WFM_DEVAD, 16'h0000);
    end
    rdchk(WFM_OFS_CTL, WFM_DEVAD, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_regs();
    set_masks(32'h0);
    wr(16'h0005, 16'hffff);
    for (int t = 0; t < 4; t++) begin
      rdchk(WFM_OFS_LOW[t], WFM_DEVAD, MK[t][15:0]);
      rdchk(WFM_OFS_HIGH[t], WFM_DEVAD, MK[t][31:16]);
    end
    rdchk(16'h0005, WFM_DEVAD, 16'h0000);
    rdchk(WFM_OFS_LOW[3], 5'h1e, 16'h0000);
    wr(WFM_OFS_CTL, 16'hffff);
    rdchk(WFM_OFS_CTL, WFM_DEVAD, 16'h003c);
    $display("test regs done");
  endtask
  task automatic t_frames();
    send_frame(8'h5a, 4'hf);
    for (int t = 0; t < 4; t++) begin
      want[t] = ref_crc(MK[t], 8'h5a);
      chk(res[t], want[t]);
    end
    // type 2 off, new masks: its result must hold
    wr(WFM_OFS_CTL, 16'h002c);
    set_masks(32'h0f0f0f0f);
    send_frame(8'h3c, 4'hb);
    for (int t = 0; t < 4; t++) begin
      if (t != 2) want[t] = ref_crc(MK[t] ^ 32'h0f0f0f0f, 8'h3c);
      chk(res[t], want[t]);
    end
    $display("test frames done");
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset();
    t_regs();
    t_frames();
    tally_and_finish();
  end
endmodule

// ---- rtl/wfm_crc_lane.sv ----
// Purpose: crc accumulator for one custom frame type
// Assumes: clear and feed come from logic on the same clock
// Notes: clear with feed starts a new crc with that byte
module wfm_crc_lane (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic clear,
  input wire logic feed,
  input wire logic [7:0] data,
  output logic [31:0] crc
);
  import wfm_pkg::*;

  logic [31:0] base;

  // restart point at frame start
  assign base = clear ? WFM_CRC_INIT : crc;

  // deselected bytes leave the crc untouched, except a deselected frame-start byte, which reloads WFM_CRC_INIT
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      crc <= WFM_CRC_INIT;
    end else if (feed) begin
      crc <= wfm_crc_step(base, data); // RQ8
    end else begin
      crc <= base;
    end
  end
endmodule

// ---- rtl/wfm_masks.sv ----
// Purpose: byte-select masks and per-type crc of the first 32 frame bytes
// Assumes: frame bytes arrive one per valid cycle, sof marks byte 1
// Notes: frames shorter than 32 bytes give no result
module wfm_masks (
  input wire logic CLK,
  input wire logic RST_N,
  input wire wfm_pkg::wfm_reg_req_t REG_REQ,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  input wire wfm_pkg::wfm_byte_t RX_BYTE,
  output logic [3:0][31:0] CRC_RESULT,
  output logic [3:0] CRC_DONE
);
  import wfm_pkg::*;

  logic [3:0][15:0] mask_low;
  logic [3:0][15:0] mask_high;
  logic [3:0] remote_wakeup_match_en;
  logic [5:0] pos_cnt;
  logic [5:0] cur_pos;
  logic [3:0] idx_low;
  logic [3:0] idx_high;
  logic in_low;
  logic in_high;
  logic [3:0] sel;
  logic [3:0] feed;
  logic [3:0][31:0] crc;
  logic last_byte;
  logic [3:0] done_pend;
  logic reg_hit;
  logic [15:0] next_rdata;

  assign reg_hit = REG_REQ.devad == WFM_DEVAD;

  // control register: only the custom type enables are held
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      remote_wakeup_match_en <= WFM_EN_RESET;
    end else if (REG_REQ.wr && reg_hit && REG_REQ.addr == WFM_OFS_CTL) begin
      remote_wakeup_match_en <= REG_REQ.wdata[WFM_EN_LSB +: WFM_TYPES];
    end
  end

  // independent mask pair per frame type
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mask_low <= {WFM_TYPES{WFM_MASK_RESET}};
      mask_high <= {WFM_TYPES{WFM_MASK_RESET}};
    end else if (REG_REQ.wr && reg_hit) begin
      for (int t = 0; t < WFM_TYPES; t++) begin
        if (REG_REQ.addr == WFM_OFS_LOW[t]) begin
          mask_low[t] <= REG_REQ.wdata; // RQ5
        end
        if (REG_REQ.addr == WFM_OFS_HIGH[t]) begin
          mask_high[t] <= REG_REQ.wdata; // RQ5
        end
      end
    end
  end

  // read mux, unmapped or foreign device reads zero
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_hit) begin
      if (REG_REQ.addr == WFM_OFS_CTL) begin
        next_rdata[WFM_EN_LSB +: WFM_TYPES] = remote_wakeup_match_en;
      end
      for (int t = 0; t < WFM_TYPES; t++) begin
        if (REG_REQ.addr == WFM_OFS_LOW[t]) begin
          next_rdata = mask_low[t];
        end
        if (REG_REQ.addr == WFM_OFS_HIGH[t]) begin
          next_rdata = mask_high[t];
        end
      end
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      REG_RDATA <= 16'h0000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_REQ.rd;
      if (REG_REQ.rd) begin
        REG_RDATA <= next_rdata;
      end
    end
  end

  // position of the byte now on the input, 1-based
  assign cur_pos = RX_BYTE.sof ? WFM_POS_FIRST : pos_cnt;
  assign in_low = cur_pos >= WFM_POS_FIRST && cur_pos <= WFM_POS_LOW_LAST; // RQ6
  assign in_high = cur_pos >= WFM_POS_HIGH_FIRST && cur_pos <= WFM_POS_LAST; // RQ3
  assign idx_low = 4'(cur_pos - WFM_POS_FIRST); // RQ2
  assign idx_high = 4'(cur_pos - WFM_POS_HIGH_FIRST); // RQ4
  assign last_byte = RX_BYTE.valid && cur_pos == WFM_POS_LAST;

  // byte counter saturates past the mask window
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pos_cnt <= WFM_POS_BEYOND;
    end else if (RX_BYTE.valid) begin
      pos_cnt <= (cur_pos >= WFM_POS_BEYOND) ? WFM_POS_BEYOND : cur_pos + 6'h01;
    end
  end

  // one crc lane per frame type
  generate
    for (genvar t = 0; t < WFM_TYPES; t++) begin : g_lane
      assign sel[t] = (in_low && mask_low[t][idx_low]) ||
        (in_high && mask_high[t][idx_high]); // RQ1
      assign feed[t] = RX_BYTE.valid && sel[t] && remote_wakeup_match_en[t]; // RQ7
      wfm_crc_lane u_lane (
        .CLK(CLK),
        .RST_N(RST_N),
        .clear(RX_BYTE.valid && RX_BYTE.sof),
        .feed(feed[t]),
        .data(RX_BYTE.data),
        .crc(crc[t])
      );
    end
  endgenerate

  // result two cycles after byte 32, only for enabled types
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      done_pend <= 4'h0;
      CRC_DONE <= 4'h0;
      CRC_RESULT <= '0;
    end else begin
      done_pend <= last_byte ? remote_wakeup_match_en : 4'h0; // RQ7
      CRC_DONE <= done_pend;
      for (int t = 0; t < WFM_TYPES; t++) begin
        if (done_pend[t]) begin
          CRC_RESULT[t] <= ~crc[t];
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_unselected_holds;
    RX_BYTE.valid && !RX_BYTE.sof && !sel[0] |=> $stable(crc[0]);
  endproperty
  a_unselected_holds: assert property (p_unselected_holds) // RQ1
    else $error("unselected byte changed crc");

  property p_low_bit0_byte1;
    RX_BYTE.valid && RX_BYTE.sof && remote_wakeup_match_en[0] |-> feed[0] == mask_low[0][0];
  endproperty
  a_low_bit0_byte1: assert property (p_low_bit0_byte1) // RQ2
    else $error("byte 1 not under low bit 0");

  property p_beyond_excluded;
    RX_BYTE.valid && cur_pos > WFM_POS_LAST |-> feed == 4'h0;
  endproperty
  a_beyond_excluded: assert property (p_beyond_excluded) // RQ3
    else $error("byte past 32 fed crc");

  property p_high_bit15_byte32;
    last_byte && remote_wakeup_match_en[3] |-> feed[3] == mask_high[3][15];
  endproperty
  a_high_bit15_byte32: assert property (p_high_bit15_byte32) // RQ4
    else $error("byte 32 not under bit 15");

  property p_type1_write_isolated;
    REG_REQ.wr && reg_hit && REG_REQ.addr == WFM_OFS_LOW[1] |=>
      mask_low[1] == $past(REG_REQ.wdata) && $stable(mask_low[0]) && $stable(mask_high[1]);
  endproperty
  a_type1_write_isolated: assert property (p_type1_write_isolated) // RQ5
    else $error("mask write leaked");

  property p_low_zero_window;
    RX_BYTE.valid && in_low && mask_low[2] == 16'h0000 |-> !feed[2];
  endproperty
  a_low_zero_window: assert property (p_low_zero_window) // RQ6
    else $error("low window byte fed with zero mask");

  property p_disabled_no_done;
    last_byte && !remote_wakeup_match_en[2] |-> ##2 !CRC_DONE[2];
  endproperty
  a_disabled_no_done: assert property (p_disabled_no_done) // RQ7
    else $error("disabled type gave result");

  property p_fed_in_order;
    feed[1] && !RX_BYTE.sof |=> crc[1] == wfm_crc_step($past(crc[1]), $past(RX_BYTE.data));
  endproperty
  a_fed_in_order: assert property (p_fed_in_order) else $error("crc not advanced by byte"); // RQ8

  property p_low_bit15_byte16;
    RX_BYTE.valid && cur_pos == WFM_POS_LOW_LAST && remote_wakeup_match_en[0] |->
      feed[0] == mask_low[0][15];
  endproperty
  a_low_bit15_byte16: assert property (p_low_bit15_byte16) // RQ2
    else $error("byte 16 not under low bit 15");

  property p_high_bit0_byte17;
    RX_BYTE.valid && cur_pos == WFM_POS_HIGH_FIRST && remote_wakeup_match_en[3] |->
      feed[3] == mask_high[3][0];
  endproperty
  a_high_bit0_byte17: assert property (p_high_bit0_byte17) // RQ4
    else $error("byte 17 not under high bit 0");

  property p_high_bit_clear;
    RX_BYTE.valid && in_high && !mask_high[3][idx_high] |-> !feed[3];
  endproperty
  a_high_bit_clear: assert property (p_high_bit_clear) // RQ3
    else $error("deselected high window byte fed");

  property p_type3_write_isolated;
    REG_REQ.wr && reg_hit && REG_REQ.addr == WFM_OFS_HIGH[3] |=>
      mask_high[3] == $past(REG_REQ.wdata) && $stable(mask_low[3]) && $stable(mask_high[2]);
  endproperty
  a_type3_write_isolated: assert property (p_type3_write_isolated) // RQ5
    else $error("high mask write leaked");

  property p_read_answer;
    REG_REQ.rd && reg_hit && REG_REQ.addr == WFM_OFS_LOW[2] |=>
      REG_RVALID && REG_RDATA == $past(mask_low[2]);
  endproperty
  a_read_answer: assert property (p_read_answer) // RQ5
    else $error("mask read answer wrong");

  property p_disabled_no_feed;
    RX_BYTE.valid && !remote_wakeup_match_en[2] |-> !feed[2];
  endproperty
  a_disabled_no_feed: assert property (p_disabled_no_feed) // RQ7
    else $error("disabled type fed crc");

  property p_done_one_cycle;
    CRC_DONE[0] |=> !CRC_DONE[0];
  endproperty
  a_done_one_cycle: assert property (p_done_one_cycle) // RQ7
    else $error("done pulse too long");

  c_result_type0: cover property (last_byte && remote_wakeup_match_en[0] ##2 CRC_DONE[0]);
  c_high_byte_fed: cover property (RX_BYTE.valid && in_high && feed[2]);
  c_mask_readback: cover property (REG_REQ.rd && reg_hit && REG_REQ.addr == WFM_OFS_HIGH[3]
    ##1 REG_RVALID);
  c_type2_skipped: cover property (last_byte && !remote_wakeup_match_en[2] ##2 !CRC_DONE[2]);
  c_frame_gap: cover property (RX_BYTE.valid ##1 (!RX_BYTE.valid && pos_cnt <= WFM_POS_LAST));
endmodule

// ---- shared/wfm_pkg.sv ----
// Purpose: constants, carriers and crc step for the wake frame byte masks
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes: register offsets sit in the vendor management space, device 1fh
//
// How it works
// RQ1 - mask bit 1 includes byte, 0 excludes
// RQ2 - low word bit n governs byte n+1
// RQ3 - high word selects frame bytes 17 to 32
// RQ4 - high word bit n governs byte n+17
// RQ5 - four types, each own writable mask pair
// RQ6 - low word covers frame bytes 1 to 16
// RQ7 - type matches only while its enable set
// RQ8 - selected bytes fed in order, others skipped
package wfm_pkg;

  localparam int WFM_TYPES = 4;
  localparam logic [4:0] WFM_DEVAD = 5'h1f;
  // wake control register and its enable field
  localparam logic [15:0] WFM_OFS_CTL = 16'h0000;
  localparam int WFM_EN_LSB = 2;
  localparam logic [3:0] WFM_EN_RESET = 4'h0;
  // byte-select mask offsets, index = frame type
  localparam logic [3:0][15:0] WFM_OFS_LOW = {16'h0013, 16'h000d, 16'h0007, 16'h0001};
  localparam logic [3:0][15:0] WFM_OFS_HIGH = {16'h0014, 16'h000e, 16'h0008, 16'h0002};
  localparam logic [15:0] WFM_MASK_RESET = 16'h0000;
  // frame byte positions
  localparam logic [5:0] WFM_POS_FIRST = 6'h01;
  localparam logic [5:0] WFM_POS_LOW_LAST = 6'h10;
  localparam logic [5:0] WFM_POS_HIGH_FIRST = 6'h11;
  localparam logic [5:0] WFM_POS_LAST = 6'h20;
  localparam logic [5:0] WFM_POS_BEYOND = 6'h21;
  // crc-32, reflected form
  localparam logic [31:0] WFM_CRC_INIT = 32'hffffffff;
  localparam logic [31:0] WFM_CRC_POLY = 32'hedb88320;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] devad;
    logic [15:0] addr;
    logic [15:0] wdata;
  } wfm_reg_req_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic [7:0] data;
  } wfm_byte_t;

  // one byte into the crc, lsb first
  function automatic logic [31:0] wfm_crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ WFM_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage
